// file: eso_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM output control block
// Assumes: 100 MHz system clock; 256 words of 16 bits
// Notes: Serial pins are sampled as ordinary inputs, not used as clocks
package eso_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int CLK_MHZ = 100;
  localparam int SYNC_STAGES = 3;
  localparam int PIN_CNT = 4;
  localparam int PIN_CS = 0;
  localparam int PIN_SK = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_T1 = 3;
  // Least time, rounded up
  localparam int SELECT_LOW_TIME_NS = 200;
  localparam int SELECT_LOW_CYC = (SELECT_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  // Longest time, rounded down
  localparam int PROGRAM_PERIOD_MS = 10;
  localparam int PROGRAM_PERIOD_CYC = PROGRAM_PERIOD_MS * CLK_MHZ * 1000;
  localparam int BULK_WORDS = 128;
  localparam int BULK_BLK_BIT = 0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_WEN = 2'h3;
  localparam logic [1:0] EXT_WDIS = 2'h0;
  localparam logic [1:0] EXT_BULK = 2'h1;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_HOLD
  } eso_state_t;
endpackage

// file: eso_mem_if.sv
// Purpose: Carrier between the control logic and the word store
// Assumes: One access per cycle
// Notes: Read data return one cycle after rd_en
`timescale 1ns/1ns
interface eso_mem_if;
  import eso_pkg::*;
  logic rd_en;
  logic wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport store (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// file: eso_mem.sv
// Purpose: Word store of the EEPROM array
// Assumes: Single port, a read in the same cycle as a write returns the old word
// Notes: Array content is not reset, like the real cells
`timescale 1ns/1ns
module eso_mem
  import eso_pkg::*;
(
  input wire logic mclk_i,  // System clock
  input wire logic rstn_i,  // Synchronous reset, active low
  eso_mem_if.store mem      // Access port
);
  logic [DATA_W-1:0] cell_q [2**ADDR_W];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb
  begin
    rdata_d = rdata_q;
    if (mem.rd_en)
    begin
      rdata_d = cell_q[mem.addr];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (mem.wr_en)
    begin
      cell_q[mem.addr] <= mem.wdata;
    end
    if (!rstn_i)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign mem.rdata = rdata_q;
endmodule

// file: eso_top.sv
// Purpose: Serial EEPROM command, read out and ready/busy output logic
// Assumes: Host pins are asynchronous and far slower than the system clock
// Notes: Serial clock edges are found by oversampling, not used as a clock
`timescale 1ns/1ns
// Summary of operation
// [R1] Output floats except during read data and ready/busy display.
// [R2] Select raised after 200 ns low, after a write, shows ready/busy.
// [R3] During programming output shows low and other commands are refused.
// [R4] Program period end shows high and the next command is taken.
// [R5] Commands while busy are dropped; while ready they end the display.
// [R6] A recognised start bit during the display floats the output at once.
// [R7] Serial in high on a clock rise with select high is a start bit.
// [R8] The clock that samples the last read address bit drives a zero.
// [R9] Host sends no command during display and holds serial in low.
// [R10] Primary test high while programming corrupts data and stays busy; the code writes the data intact and only keeps busy set.
// [R11] Primary test never affects write enable, write disable or read.
// [R12] Secondary test input is ignored.
// [R13] First one after select rises is the start bit; zeros are skipped.
// [R14] Select low before the next clock rise starts programming; later clocks cancel.
// [R15] Output floats while select is low.
module eso_top
  import eso_pkg::*;
#(
  parameter int PROG_CYC = PROGRAM_PERIOD_CYC
)
(
  input wire logic mclk_i,                // System clock
  input wire logic rstn_i,                // Synchronous reset, active low
  input wire logic chip_select_i,         // Chip select pin
  input wire logic serial_clock_pin_i,    // Serial clock pin
  input wire logic serial_in_pin_i,       // Serial data in pin
  input wire logic primary_test_input_i,  // Primary test pin
  input wire logic secondary_test_input_i, // Secondary test pin, no effect
  output logic serial_out_o,              // Serial data out level
  output logic serial_out_oe_o            // High while the output is driven
);
  logic [PIN_CNT-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic cs, sk, di, t1, cs_prev_q, sk_prev_q, sk_rise, cs_rise, cs_fall;
  eso_state_t st_q, st_d;
  logic [1:0] opc_q, opc_d;
  logic [ADDR_W-1:0] addr_q, addr_d, full_addr;
  logic [DATA_W-1:0] data_q, data_d, sh_q, sh_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, low_q, low_d;
  logic [31:0] timer_q, timer_d;
  logic [6:0] bcnt_q, bcnt_d;
  logic wen_q, wen_d, busy_q, busy_d, stuck_q, stuck_d, bulk_q, bulk_d;
  logic arm_q, arm_d, show_q, show_d, pend_q, pend_d, pbulk_q, pbulk_d;
  logic so_q, so_d, oe_q, oe_d, load_q, rd_en, wr_en;
  logic [ADDR_W-1:0] m_addr;
  logic [DATA_W-1:0] m_wdata;

  eso_mem_if mif ();

  eso_mem u_mem (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .mem(mif.store)
  );

  // Glitch filter: a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < PIN_CNT; g++)
    begin : g_filt
      assign filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      cs_prev_q <= 1'b0;
      sk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {primary_test_input_i, serial_in_pin_i, serial_clock_pin_i, chip_select_i}; // R12
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      cs_prev_q <= filt_q[PIN_CS];
      sk_prev_q <= filt_q[PIN_SK];
    end
  end

  assign cs = filt_q[PIN_CS];
  assign sk = filt_q[PIN_SK];
  assign di = filt_q[PIN_DI];
  assign t1 = filt_q[PIN_T1];
  assign sk_rise = sk && !sk_prev_q && cs;
  assign cs_rise = cs && !cs_prev_q;
  assign cs_fall = !cs && cs_prev_q;
  assign full_addr = {addr_q[ADDR_W-2:0], di};

  always_comb
  begin
    st_d = st_q;
    opc_d = opc_q;
    addr_d = addr_q;
    data_d = data_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    timer_d = timer_q;
    bcnt_d = bcnt_q;
    wen_d = wen_q;
    busy_d = busy_q;
    stuck_d = stuck_q;
    bulk_d = bulk_q;
    arm_d = arm_q;
    show_d = show_q;
    pend_d = pend_q;
    pbulk_d = pbulk_q;
    so_d = so_q;
    oe_d = oe_q;
    rd_en = 1'b0;
    wr_en = 1'b0;
    m_addr = addr_q;
    m_wdata = data_q;
    low_d = cs ? '0 : ((low_q == '1) ? low_q : low_q + 1'b1);
    // Self-timed programming
    if (busy_q)
    begin
      if (t1)
      begin
        stuck_d = 1'b1; // R10
      end
      if (bulk_q)
      begin
        wr_en = 1'b1;
        m_addr = {addr_q[BULK_BLK_BIT], bcnt_q};
        bcnt_d = bcnt_q + 1'b1;
        bulk_d = (bcnt_q != 7'(BULK_WORDS - 1));
      end
      // A stuck timer never ends the busy period
      if (!stuck_q && !t1)
      begin
        timer_d = timer_q + 1'b1;
        if (timer_q == 32'(PROG_CYC - 1) && !bulk_q)
        begin
          busy_d = 1'b0; // R4
        end
      end
    end
    if (!cs)
    begin
      st_d = ST_IDLE;
      show_d = 1'b0;
      oe_d = 1'b0; // R15
      if (cs_fall && pend_q)
      begin
        pend_d = 1'b0;
        // Write is dropped silently when disabled
        if (wen_q)
        begin
          busy_d = 1'b1; // R14
          timer_d = '0;
          arm_d = 1'b1;
          bulk_d = pbulk_q;
          bcnt_d = '0;
          wr_en = !pbulk_q;
        end
      end
    end
    else if (cs_rise)
    begin
      if (arm_q && low_q >= CNT_W'(SELECT_LOW_CYC))
      begin
        show_d = 1'b1; // R2
        oe_d = 1'b1;
        so_d = !busy_q;
      end
    end
    else if (show_q)
    begin
      so_d = !busy_q; // R3 R4
      if (sk_rise && di && !busy_q)
      begin
        show_d = 1'b0; // R6 R7
        oe_d = 1'b0;
        arm_d = 1'b0; // R5
        st_d = ST_OPC;
        cnt_d = '0;
      end
    end
    else if (sk_rise)
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          // Zeros before the start bit and commands while busy are dropped
          if (di && !busy_q)
          begin
            st_d = ST_OPC; // R13 R3
            cnt_d = '0;
            arm_d = 1'b0;
          end
        end
        ST_OPC:
        begin
          opc_d = {opc_q[0], di};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(1))
          begin
            st_d = ST_ADDR;
            cnt_d = '0;
          end
        end
        ST_ADDR:
        begin
          addr_d = full_addr;
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(ADDR_W - 1))
          begin
            cnt_d = '0;
            st_d = ST_HOLD;
            if (opc_q == OP_READ)
            begin
              st_d = ST_READ; // R11
              oe_d = 1'b1;
              so_d = 1'b0; // R8
              rd_en = 1'b1;
              m_addr = full_addr;
            end
            else if (opc_q == OP_WRITE || full_addr[ADDR_W-1 -: 2] == EXT_BULK)
            begin
              st_d = ST_DATA;
              pbulk_d = (opc_q == OP_EXT);
            end
            else if (full_addr[ADDR_W-1 -: 2] == EXT_WEN)
            begin
              wen_d = 1'b1; // R11
            end
            else if (full_addr[ADDR_W-1 -: 2] == EXT_WDIS)
            begin
              wen_d = 1'b0; // R11
            end
          end
        end
        ST_DATA:
        begin
          data_d = {data_q[DATA_W-2:0], di};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(DATA_W - 1))
          begin
            pend_d = 1'b1;
            st_d = ST_HOLD;
          end
        end
        ST_READ:
        begin
          so_d = sh_q[DATA_W-1];
          sh_d = {sh_q[DATA_W-2:0], 1'b0};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(DATA_W - 1))
          begin
            cnt_d = '0;
            addr_d = addr_q + 1'b1;
            rd_en = 1'b1;
            m_addr = addr_q + 1'b1;
          end
        end
        ST_HOLD:
        begin
          pend_d = 1'b0; // R14
        end
      endcase
    end
    if (load_q)
    begin
      sh_d = mif.rdata;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      st_q <= ST_IDLE;
      opc_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      sh_q <= '0;
      cnt_q <= '0;
      low_q <= '0;
      timer_q <= '0;
      bcnt_q <= '0;
      wen_q <= 1'b0;
      busy_q <= 1'b0;
      stuck_q <= 1'b0;
      bulk_q <= 1'b0;
      arm_q <= 1'b0;
      show_q <= 1'b0;
      pend_q <= 1'b0;
      pbulk_q <= 1'b0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      data_q <= data_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      timer_q <= timer_d;
      bcnt_q <= bcnt_d;
      wen_q <= wen_d;
      busy_q <= busy_d;
      stuck_q <= stuck_d;
      bulk_q <= bulk_d;
      arm_q <= arm_d;
      show_q <= show_d;
      pend_q <= pend_d;
      pbulk_q <= pbulk_d;
      so_q <= so_d;
      oe_q <= oe_d;
      load_q <= rd_en;
    end
  end

  assign mif.rd_en = rd_en;
  assign mif.wr_en = wr_en;
  assign mif.addr = m_addr;
  assign mif.wdata = m_wdata;
  assign serial_out_o = so_q;
  assign serial_out_oe_o = oe_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_float_sel_low: assert property (!cs |=> !oe_q) // R15
    else $error("output driven with select low");
  chk_drive_cause: assert property (oe_q |-> (show_q || st_q == ST_READ)) // R1
    else $error("output driven outside read or status");
  chk_status_shown: assert property ( // R2
    (cs_rise && arm_q && low_q >= CNT_W'(SELECT_LOW_CYC)) |=> (show_q && oe_q))
    else $error("status not shown after select low time");
  chk_busy_low_out: assert property ( // R3
    (show_q && busy_q && $past(busy_q) && $past(show_q)) |-> !so_q)
    else $error("busy not shown low");
  chk_busy_refuse: assert property ( // R5
    (busy_q && st_q == ST_IDLE) |=> st_q == ST_IDLE)
    else $error("command taken while busy");
  chk_ready_high: assert property ( // R4
    (show_q && $past(show_q) && !$past(busy_q)) |-> so_q)
    else $error("ready not shown high");
  chk_timer_end: assert property ( // R4
    (busy_q && !stuck_q && !t1 && !bulk_q && timer_q == 32'(PROG_CYC - 1)) |=> !busy_q)
    else $error("program period did not end");
  chk_start_float: assert property ( // R7
    (show_q && sk_rise && di && !busy_q) |=> (!oe_q && st_q == ST_OPC))
    else $error("start bit did not float output");
  chk_dummy_zero: assert property ( // R8
    (st_q == ST_ADDR && sk_rise && opc_q == OP_READ && cnt_q == CNT_W'(ADDR_W - 1))
    |=> (oe_q && !so_q && st_q == ST_READ))
    else $error("dummy zero missing");
  chk_stuck_busy: assert property (stuck_q |=> (busy_q && stuck_q)) // R10
    else $error("stuck program left busy");
  chk_prog_start: assert property ((pend_q && cs_fall && wen_q) |=> busy_q) // R14
    else $error("program did not start");
  chk_late_cancel: assert property ((pend_q && sk_rise) |=> !pend_q) // R14
    else $error("late clock did not cancel write");
  chk_zero_skip: assert property ( // R13
    (st_q == ST_IDLE && cs && !cs_rise && !show_q && sk_rise && !di) |=> st_q == ST_IDLE)
    else $error("zero taken as start bit");

  cov_read_out: cover property (st_q == ST_READ && sk_rise);
  cov_busy_shown: cover property (show_q && busy_q);
  cov_ready_then_start: cover property (show_q && !busy_q ##1 !show_q && st_q == ST_OPC);
  cov_bulk_write: cover property (bulk_q);
endmodule

// file: eso_host_model.sv
// Purpose: Host model driving the three-wire serial bus of the block
// Assumes: Pins change on falling system clock edges, slow against the filters
// Notes: Serial clock stands low outside frames; pull level is chosen by the board
`timescale 1ns/1ns
module eso_host_model
(
  input wire logic mclk_i,  // System clock
  input wire logic line_i,  // Resolved serial out line
  output logic cs_o,        // Chip select
  output logic sk_o,        // Serial clock
  output logic di_o         // Serial data in
);
  initial
  begin
    cs_o = 1'h0;
    sk_o = 1'h0;
    di_o = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Data low before select moves, so no stray start bit on the status display
  task automatic sel(input logic v);
    di_o = 1'h0;
    wt(4);
    cs_o = v;
    wt(8);
  endtask

  // Line sampled late in the high phase, once the answer has settled
  task automatic clk_bit(input logic b, output logic q);
    di_o = b;
    wt(4);
    sk_o = 1'h1;
    wt(6);
    q = line_i;
    sk_o = 1'h0;
    wt(4);
  endtask

  task automatic xfer(input logic [26:0] v, output logic [26:0] s);
    logic q;
    s = '0;
    for (int i = 26; i >= 0; i--)
    begin
      clk_bit(v[i], q);
      s = {s[25:0], q};
    end
  endtask
endmodule

// file: test_eeprom_status_output_control.sv
// Purpose: Self-checking bench for the serial EEPROM output control block
// Assumes: Program period shortened to 300 cycles; memory content not reset
// Notes: Frames are 27 clocks, 28 in the cancel test; short commands are padded with leading zeros
`timescale 1ns/1ns
module test_eeprom_status_output_control;
  import eso_pkg::*;
  localparam int PCYC = 300;
  logic mclk;
  logic rstn;
  logic t1;
  logic t2;
  logic pull;
  logic cs;
  logic sk;
  logic di;
  logic so;
  logic soe;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  // Pull level switchable so that a float shows as a wrong bit
  wire logic line = soe ? so : pull;

  eso_top #(.PROG_CYC(PCYC)) u_eso_top (
    .mclk_i(mclk),
    .rstn_i(rstn),
    .chip_select_i(cs),
    .serial_clock_pin_i(sk),
    .serial_in_pin_i(di),
    .primary_test_input_i(t1),
    .secondary_test_input_i(t2),
    .serial_out_o(so),
    .serial_out_oe_o(soe)
  );

  eso_host_model u_eso_host_model (
    .mclk_i(mclk),
    .line_i(line),
    .cs_o(cs),
    .sk_o(sk),
    .di_o(di)
  );

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic chk1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [26:0] f_ext(input logic [1:0] c);
    return {16'h0000, 1'h1, OP_EXT, c, 6'h00};
  endfunction

  function automatic logic [26:0] f_wr(input logic [7:0] a, input logic [15:0] d);
    return {1'h1, OP_WRITE, a, d};
  endfunction

  function automatic logic [26:0] f_rd(input logic [7:0] a);
    return {1'h1, OP_READ, a, 16'h0000};
  endfunction

  function automatic logic [26:0] f_bulk(input logic b, input logic [15:0] d);
    return {1'h1, OP_EXT, EXT_BULK, 5'h00, b, d};
  endfunction

  task automatic send(input logic [26:0] v, output logic [26:0] s);
    u_eso_host_model.sel(1'h1);
    u_eso_host_model.xfer(v, s);
    u_eso_host_model.sel(1'h0);
  endtask

  // Leaves select high so the caller can judge the status display
  task automatic wr_status(input logic [26:0] v);
    logic [26:0] s;
    u_eso_host_model.sel(1'h1);
    u_eso_host_model.xfer(v, s);
    u_eso_host_model.sel(1'h0);
    u_eso_host_model.wt(25);
    u_eso_host_model.sel(1'h1);
  endtask

  task automatic t_idle();
    chk1("oe after reset", 1'h0, soe);
    u_eso_host_model.sel(1'h1);
    chk1("oe selected idle", 1'h0, soe);
    u_eso_host_model.sel(1'h0);
  endtask

  task automatic t_write_status();
    logic [26:0] s;
    logic q;
    send(f_ext(EXT_WEN), s);
    wr_status(f_wr(8'h5a, 16'ha5c3));
    chk1("status oe", 1'h1, soe);
    chk1("busy level", 1'h0, line);
    // Deliberate command while busy, must be dropped
    repeat (3) u_eso_host_model.clk_bit(1'h1, q);
    chk1("busy oe kept", 1'h1, soe);
    chk1("busy kept", 1'h0, line);
    u_eso_host_model.wt(PCYC);
    chk1("ready level", 1'h1, line);
    pull = 1'h0;
    u_eso_host_model.xfer(f_rd(8'h5a), s);
    u_eso_host_model.sel(1'h0);
    pull = 1'h1;
    chk1("float on start", 1'h0, s[26]);
    chk1("dummy bit", 1'h0, s[16]);
    chk16("read after ready", 16'ha5c3, s[15:0]);
    chk1("oe select low", 1'h0, soe);
  endtask

  task automatic t_cancel();
    logic [26:0] s;
    logic q;
    u_eso_host_model.sel(1'h1);
    u_eso_host_model.xfer(f_wr(8'h5a, 16'h1234), s);
    u_eso_host_model.clk_bit(1'h0, q);
    u_eso_host_model.sel(1'h0);
    u_eso_host_model.wt(25);
    u_eso_host_model.sel(1'h1);
    chk1("no status", 1'h0, soe);
    u_eso_host_model.sel(1'h0);
    send(f_rd(8'h5a), s);
    chk1("dummy bit", 1'h0, s[16]);
    chk16("kept data", 16'ha5c3, s[15:0]);
  endtask

  task automatic t_test_pins();
    logic [26:0] s;
    t1 = 1'h1;
    t2 = 1'h1;
    send(f_rd(8'h5a), s);
    chk16("read test high", 16'ha5c3, s[15:0]);
    send(f_ext(EXT_WDIS), s);
    wr_status(f_wr(8'h33, 16'h0f0f));
    chk1("disabled no status", 1'h0, soe);
    u_eso_host_model.sel(1'h0);
    send(f_ext(EXT_WEN), s);
    wr_status(f_wr(8'h33, 16'h0f0f));
    chk1("enabled status", 1'h1, soe);
    u_eso_host_model.wt(PCYC + 100);
    chk1("stuck busy", 1'h0, line);
    u_eso_host_model.sel(1'h0);
    t1 = 1'h0;
    rstn = 1'h0;
    u_eso_host_model.wt(3);
    rstn = 1'h1;
    u_eso_host_model.wt(4);
    chk1("oe after reset", 1'h0, soe);
    send(f_rd(8'h5a), s);
    chk16("read after reset", 16'ha5c3, s[15:0]);
  endtask

  // Upper block only, so words written earlier in the lower block must survive
  task automatic t_bulk();
    logic [26:0] s;
    send(f_ext(EXT_WEN), s);
    wr_status(f_bulk(1'h1, 16'h3c3c));
    chk1("bulk status oe", 1'h1, soe);
    chk1("bulk busy level", 1'h0, line);
    u_eso_host_model.wt(PCYC);
    chk1("bulk ready level", 1'h1, line);
    u_eso_host_model.sel(1'h0);
    send(f_rd(8'hc7), s);
    chk1("bulk dummy bit", 1'h0, s[16]);
    chk16("bulk word", 16'h3c3c, s[15:0]);
    send(f_rd(8'h5a), s);
    chk16("other block kept", 16'ha5c3, s[15:0]);
  endtask

  initial
  begin
    rstn = 1'h0;
    t1 = 1'h0;
    t2 = 1'h0;
    pull = 1'h1;
    repeat (3) @(negedge mclk);
    rstn = 1'h1;
    u_eso_host_model.wt(4);
    t_idle();
    t_write_status();
    t_cancel();
    t_test_pins();
    t_bulk();
    summarize();
  end
endmodule
